// [rtl/iop_consts.svh]
// Constants for the general-purpose port and counter command block.
// Assumes it is included by bare name from files under rtl/.
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets on the 4-bit address pins
// ---------------------------------------------------------------
`define IOP_ADDR_W 4
`define IOP_OFF_INTERRUPT_MASK 4'h5
`define IOP_OFF_COUNT_VALUE_HIGH 4'h6
`define IOP_OFF_COUNT_VALUE_LOW 4'h7
`define IOP_OFF_INPUT_LEVEL 4'hD
`define IOP_OFF_COUNTER_START 4'hE
`define IOP_OFF_COUNTER_STOP 4'hF
`define IOP_OFF_OUTPUT_DRIVE_LOW 4'hE
`define IOP_OFF_OUTPUT_RELEASE_HIGH 4'hF

// ---------------------------------------------------------------
// Field positions and widths
// ---------------------------------------------------------------
`define IOP_DATA_W 8
`define IOP_INPUTS_W 7
`define IOP_OUTPUTS_W 8
`define IOP_COUNT_W 16
`define IOP_MASK_BIT_BREAK_B 6
`define IOP_MASK_BIT_INPUT_CHANGE 7
`define IOP_INPUT_LEVEL_UNUSED_BIT 7

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IOP_RST_INTERRUPT_MASK 8'h00
`define IOP_RST_OUTPUT_PORT_BITS 8'h00
`define IOP_RST_READ_DATA 8'h00
`define IOP_RST_PINS 22'h3F_FFFF

`endif

// [rtl/iop_pkg.sv]
// Types shared by the port and counter command block.
// Assumes iop_consts.svh is on the include path.
`include "iop_consts.svh"

package iop_pkg;

   // ------------------------------------------------------------
   // Host bus access phase, one-hot
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      IOP_BUS_IDLE = 3'b001,
      IOP_BUS_READ = 3'b010,
      IOP_BUS_WRITE = 3'b100
   } iop_bus_e;

   // ------------------------------------------------------------
   // Pin bundle passed through the synchroniser
   // ------------------------------------------------------------
   typedef struct packed {
      logic [`IOP_ADDR_W-1:0] addr;
      logic cs_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic [`IOP_DATA_W-1:0] data;
      logic [`IOP_INPUTS_W-1:0] general_inputs;
   } iop_pins_s;

   // ------------------------------------------------------------
   // Whole state of the top module
   // ------------------------------------------------------------
   typedef struct packed {
      iop_bus_e bus;
      logic [`IOP_ADDR_W-1:0] addr;
      logic [`IOP_DATA_W-1:0] wdata;
      logic [`IOP_DATA_W-1:0] interrupt_mask;
      logic [`IOP_OUTPUTS_W-1:0] output_port_bits;
      logic [`IOP_DATA_W-1:0] rdata;
      logic data_oe;
      logic start;
      logic stop;
      logic int_n;
      logic [`IOP_OUTPUTS_W-1:0] general_outputs;
   } iop_state_s;

endpackage

// [rtl/iop_pin_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes one clock; each bit is accepted once stages two and three agree.
`timescale 1ns/100ps

module iop_pin_sync #(
   parameter int W = 22,
   parameter logic [W-1:0] RESET_VAL = '1
) (
   input wire logic CLK, // System clock
   input wire logic RST, // Synchronous reset, active high
   input wire logic CE, // Clock enable, freezes state when low
   input wire logic [W-1:0] PIN_IN, // Raw asynchronous levels
   output logic [W-1:0] PIN_OUT // Filtered, agreed levels
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] agreed;
   } iop_sync_s;

   iop_sync_s q;
   iop_sync_s d;
   logic [W-1:0] differ;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // First stage feeds only the second, so metastability stays contained
   always_comb begin
      d = q;
      d.s1 = PIN_IN;
      d.s2 = q.s1;
      d.s3 = q.s2;
      differ = q.s2 ^ q.s3;
      d.agreed = (~differ & q.s3) | (differ & q.agreed);
   end

   // Register the state
   always_ff @(posedge CLK) begin
      if (CE) begin
         if (RST) begin
            q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, agreed: RESET_VAL};
         end else begin
            q <= d;
         end
      end
   end

   assign PIN_OUT = q.agreed;

endmodule // iop_pin_sync

// [rtl/iop_port_cmd.sv]
// General-purpose port, interrupt mask and counter command registers.
// Assumes a host on asynchronous read/write strobe pins, and that
// interrupt status, count value and output selects come from logic on CLK.
// Pins pass four flops, so an access is seen four edges late.
// Strobes need about two clock periods low and high to be seen.
// Command pulses last one cycle; a held read gives only one.
`timescale 1ns/100ps
`include "iop_consts.svh"

module iop_port_cmd (
   input wire logic CLK, // System clock, 20 MHz
   input wire logic RST, // Synchronous reset, active high
   input wire logic CE, // Clock enable, freezes all state when low
   input wire logic [3:0] ADDR, // Register address pins
   input wire logic CS_N, // Chip select, active low
   input wire logic READ_STROBE_N, // Read strobe, active low
   input wire logic WRITE_STROBE_N, // Write strobe, active low
   input wire logic [7:0] DATA_IN, // Data pins, input side
   output logic [7:0] DATA_OUT, // Data pins, output side
   output logic DATA_OE, // Data pins driven while high
   input wire logic [6:0] GENERAL_INPUTS, // General-purpose input pins
   input wire logic [7:0] INTERRUPT_STATUS, // Interrupt status from the core
   input wire logic [15:0] COUNT_VALUE, // Current counter value
   input wire logic [7:0] OUTPUT_FUNCTION_SELECT, // One per pin: 0 port bit, 1 alternate
   input wire logic [7:0] ALT_OUTPUTS, // Alternate function levels
   output logic [7:0] GENERAL_OUTPUTS, // General-purpose output pins
   output logic [7:0] OUTPUT_PORT_BITS, // Stored port bits for the core
   output logic INT_N, // Interrupt output, active low
   output logic COUNTER_START, // One-cycle start command
   output logic COUNTER_STOP // One-cycle stop command
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   iop_pkg::iop_state_s q;
   iop_pkg::iop_state_s d;
   iop_pkg::iop_pins_s raw_pins;
   iop_pkg::iop_pins_s pins;
   logic read_active;
   logic write_active;
   iop_pkg::iop_bus_e access_now;
   logic [`IOP_DATA_W-1:0] masked_status;

   // ------------------------------------------------------------
   // Read data selection
   // ------------------------------------------------------------
   // Unmapped and command addresses read as zero
   function automatic logic [`IOP_DATA_W-1:0] read_mux(
      input logic [`IOP_ADDR_W-1:0] a,
      input logic [`IOP_DATA_W-1:0] mask,
      input logic [`IOP_INPUTS_W-1:0] levels,
      input logic [`IOP_COUNT_W-1:0] count
   );
      logic [`IOP_DATA_W-1:0] r;
      r = `IOP_RST_READ_DATA;
      case (a)
         `IOP_OFF_INTERRUPT_MASK: begin
            r = mask;
         end
         `IOP_OFF_INPUT_LEVEL: begin
            r = {1'b0, levels};
         end
         `IOP_OFF_COUNT_VALUE_HIGH: begin
            r = count[`IOP_COUNT_W-1:`IOP_DATA_W];
         end
         `IOP_OFF_COUNT_VALUE_LOW: begin
            r = count[`IOP_DATA_W-1:0];
         end
         `IOP_OFF_COUNTER_START: begin
            r = `IOP_RST_READ_DATA;
         end
         `IOP_OFF_COUNTER_STOP: begin
            r = `IOP_RST_READ_DATA;
         end
         default: begin
            r = `IOP_RST_READ_DATA; // Unmapped addresses read zero
         end
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // Access request decode
   // ------------------------------------------------------------
   // Read wins when both strobes show together; select gates both
   function automatic iop_pkg::iop_bus_e access_kind(
      input logic cs_n,
      input logic rd_n,
      input logic wr_n
   );
      iop_pkg::iop_bus_e k;
      k = iop_pkg::IOP_BUS_IDLE;
      if (!cs_n && !rd_n) begin
         k = iop_pkg::IOP_BUS_READ;
      end else if (!cs_n && !wr_n) begin
         k = iop_pkg::IOP_BUS_WRITE;
      end
      return k;
   endfunction

   // Command reads are recognised by address alone
   function automatic logic cmd_hit(
      input logic [`IOP_ADDR_W-1:0] a,
      input logic [`IOP_ADDR_W-1:0] off
   );
      return (a == off);
   endfunction

   // ------------------------------------------------------------
   // Output pin levels
   // ------------------------------------------------------------
   // Stored one means low; alternate levels pass straight through
   function automatic logic [`IOP_OUTPUTS_W-1:0] pin_levels(
      input logic [`IOP_OUTPUTS_W-1:0] sel,
      input logic [`IOP_OUTPUTS_W-1:0] alt,
      input logic [`IOP_OUTPUTS_W-1:0] port_bits
   );
      logic [`IOP_OUTPUTS_W-1:0] p;
      p = '1;
      for (int i = 0; i < `IOP_OUTPUTS_W; i++) begin
         p[i] = sel[i] ? alt[i] : ~port_bits[i];
      end
      return p;
   endfunction

   // ------------------------------------------------------------
   // Port bit update on a committed write
   // ------------------------------------------------------------
   // Drive-low and release-high share one stored byte, so a pin
   // set low stays low until a release write names it
   function automatic logic [`IOP_OUTPUTS_W-1:0] port_after_write(
      input logic [`IOP_ADDR_W-1:0] a,
      input logic [`IOP_DATA_W-1:0] wd,
      input logic [`IOP_OUTPUTS_W-1:0] port_bits
   );
      logic [`IOP_OUTPUTS_W-1:0] p;
      p = port_bits;
      case (a)
         `IOP_OFF_OUTPUT_DRIVE_LOW: begin
            p = port_bits | wd;
         end
         `IOP_OFF_OUTPUT_RELEASE_HIGH: begin
            p = port_bits & ~wd;
         end
         default: begin
            p = port_bits; // Other writes leave pins alone
         end
      endcase
      return p;
   endfunction

   // ------------------------------------------------------------
   // Reset state
   // ------------------------------------------------------------
   // Outputs high, interrupt masked off, no access in flight
   function automatic iop_pkg::iop_state_s reset_state();
      iop_pkg::iop_state_s s;
      s.bus = iop_pkg::IOP_BUS_IDLE;
      s.addr = '0;
      s.wdata = '0;
      s.interrupt_mask = `IOP_RST_INTERRUPT_MASK;
      s.output_port_bits = `IOP_RST_OUTPUT_PORT_BITS;
      s.rdata = `IOP_RST_READ_DATA;
      s.data_oe = 1'b0;
      s.start = 1'b0;
      s.stop = 1'b0;
      s.int_n = 1'b1;
      s.general_outputs = '1;
      return s;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   // Address, select, strobes and data share one path, so they
   // arrive aligned and a write sees its data with its strobe
   assign raw_pins.addr = ADDR;
   assign raw_pins.cs_n = CS_N;
   assign raw_pins.read_strobe_n = READ_STROBE_N;
   assign raw_pins.write_strobe_n = WRITE_STROBE_N;
   assign raw_pins.data = DATA_IN;
   assign raw_pins.general_inputs = GENERAL_INPUTS;

   iop_pin_sync #(
      .W($bits(iop_pkg::iop_pins_s)),
      .RESET_VAL(`IOP_RST_PINS)
   ) u_pin_sync (
      .CLK(CLK),
      .RST(RST),
      .CE(CE),
      .PIN_IN(raw_pins),
      .PIN_OUT(pins)
   );

   // Strobe qualification
   assign access_now = access_kind(pins.cs_n, pins.read_strobe_n, pins.write_strobe_n);
   assign read_active = (access_now == iop_pkg::IOP_BUS_READ);
   assign write_active = !pins.cs_n && !pins.write_strobe_n;

   // Every status bit gated by its own mask bit
   assign masked_status = INTERRUPT_STATUS & q.interrupt_mask;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      d.start = 1'b0;
      d.stop = 1'b0;

      // Interrupt: any status bit with its mask bit set pulls low
      d.int_n = ~(|masked_status);

      // Output pins: complement of port bit unless alternate selected
      d.general_outputs = pin_levels(OUTPUT_FUNCTION_SELECT, ALT_OUTPUTS, q.output_port_bits);

      unique case (q.bus)
         iop_pkg::IOP_BUS_IDLE: begin
            // Read takes priority if both strobes appear together
            if (read_active) begin
               d.bus = iop_pkg::IOP_BUS_READ;
               d.addr = pins.addr;
               d.data_oe = 1'b1;
               d.rdata = read_mux(pins.addr, q.interrupt_mask, pins.general_inputs, COUNT_VALUE);
               // Command reads touch nothing stored, they only pulse
               d.start = cmd_hit(pins.addr, `IOP_OFF_COUNTER_START);
               d.stop = cmd_hit(pins.addr, `IOP_OFF_COUNTER_STOP);
            end else if (write_active) begin
               // Data is captured with its strobe, through the same flops
               d.bus = iop_pkg::IOP_BUS_WRITE;
               d.addr = pins.addr;
               d.wdata = pins.data;
            end
         end
         iop_pkg::IOP_BUS_READ: begin
            // Data stays latched for the whole strobe, one command per read
            if (!read_active) begin
               d.bus = iop_pkg::IOP_BUS_IDLE;
               d.data_oe = 1'b0;
               d.rdata = `IOP_RST_READ_DATA; // Bus reads zero between accesses
            end
         end
         iop_pkg::IOP_BUS_WRITE: begin
            if (write_active) begin
               // Track data while strobe is low; value before release is used
               d.wdata = pins.data;
            end else begin
               // Release seen: commit the last data held under the strobe
               d.bus = iop_pkg::IOP_BUS_IDLE;
               d.output_port_bits = port_after_write(q.addr, q.wdata, q.output_port_bits);
               if (q.addr == `IOP_OFF_INTERRUPT_MASK) begin
                  d.interrupt_mask = q.wdata;
               end
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // Reset also waits for the enable, so a frozen block stays frozen
   always_ff @(posedge CLK) begin
      if (CE) begin
         if (RST) begin
            q <= reset_state();
         end else begin
            q <= d;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flip-flops
   // ------------------------------------------------------------
   // Bus side
   assign DATA_OUT = q.rdata;
   assign DATA_OE = q.data_oe;
   // Pin side
   assign GENERAL_OUTPUTS = q.general_outputs;
   // Core side
   assign OUTPUT_PORT_BITS = q.output_port_bits;
   assign INT_N = q.int_n;
   assign COUNTER_START = q.start;
   assign COUNTER_STOP = q.stop;

endmodule // iop_port_cmd

// [sim/iop_port_cmd_sva.sv]
// Port timing checker for iop_port_cmd.
// Assumes a host that holds ADDR through each access.
`timescale 1ns/100ps

module iop_port_cmd_sva (
   input wire logic CLK, // Clock
   input wire logic RST, // Reset
   input wire logic CE, // Clock enable
   input wire logic [3:0] ADDR, // Address
   input wire logic READ_STROBE_N, // Read strobe
   input wire logic [7:0] DATA_OUT, // Read data
   input wire logic DATA_OE, // Data enable
   input wire logic [7:0] INTERRUPT_STATUS, // Status
   input wire logic [15:0] COUNT_VALUE, // Count
   input wire logic [7:0] OUTPUT_FUNCTION_SELECT, // Select
   input wire logic [7:0] ALT_OUTPUTS, // Alternate levels
   input wire logic [7:0] GENERAL_OUTPUTS, // Pins
   input wire logic [7:0] OUTPUT_PORT_BITS, // Port bits
   input wire logic INT_N, // Interrupt
   input wire logic COUNTER_START, // Start pulse
   input wire logic COUNTER_STOP // Stop pulse
);
   // ---------------------------------------------
   // Relations at the ports
   // ---------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   chk_int_quiet: assert property (
      !$past(RST) && $past(CE) && $past(INTERRUPT_STATUS) == 8'h00 |-> INT_N) else $error("interrupt without status");
   chk_out_map: assert property (
      !$past(RST) && $past(CE) |-> GENERAL_OUTPUTS == (($past(OUTPUT_FUNCTION_SELECT) & $past(ALT_OUTPUTS))
         | (~$past(OUTPUT_FUNCTION_SELECT) & ~$past(OUTPUT_PORT_BITS)))) else $error("pin map wrong");
   chk_start_once: assert property (
      COUNTER_START |=> !COUNTER_START) else $error("start pulse too long");
   chk_start_addr: assert property (
      COUNTER_START |-> $rose(DATA_OE) && ADDR == 4'hE) else $error("start without its read");
   chk_stop_addr: assert property (
      COUNTER_STOP |-> $rose(DATA_OE) && ADDR == 4'hF) else $error("stop without its read");
   chk_oe_release: assert property (
      $rose(READ_STROBE_N) |-> ##[1:5] !DATA_OE) else $error("data enable stuck");
   chk_unused_bit: assert property (
      $rose(DATA_OE) && ADDR == 4'hD |-> !DATA_OUT[7]) else $error("input level bit 7 set");
   chk_count_bytes: assert property (
      $rose(DATA_OE) && ADDR[3:1] == 3'b011
      |-> DATA_OUT == (ADDR[0] ? $past(COUNT_VALUE[7:0]) : $past(COUNT_VALUE[15:8])))
      else $error("count byte wrong");
   chk_port_hold: assert property (
      !READ_STROBE_N |=> $stable(OUTPUT_PORT_BITS)) else $error("port bits moved on read");
endmodule // iop_port_cmd_sva

bind iop_port_cmd iop_port_cmd_sva i_chk (.CLK, .RST, .CE, .ADDR, .READ_STROBE_N, .DATA_OUT, .DATA_OE,
   .INTERRUPT_STATUS, .COUNT_VALUE, .OUTPUT_FUNCTION_SELECT, .ALT_OUTPUTS, .GENERAL_OUTPUTS,
   .OUTPUT_PORT_BITS, .INT_N, .COUNTER_START, .COUNTER_STOP);

// [sim/iop_host_model.sv]
// Host CPU on the read/write strobe pins.
// Assumes callers enter its tasks 5 ns after a rising edge.
`timescale 1ns/100ps

module iop_host_model (
   input wire logic CLK, // Clock
   output logic [3:0] ADDR, // Address
   output logic CS_N, // Chip select
   output logic READ_STROBE_N, // Read strobe
   output logic WRITE_STROBE_N, // Write strobe
   output logic [7:0] DATA_IN, // Data pin level
   input wire logic [7:0] DATA_OUT, // Device data
   input wire logic DATA_OE // Device drives data
);
   logic [7:0] host_d = 8'hA5;
   int timeouts = 0; // Reads that never saw data enable
   initial begin
      ADDR = 4'h0;
      CS_N = 1'b1;
      READ_STROBE_N = 1'b1;
      WRITE_STROBE_N = 1'b1;
   end
   // Pin level: device wins while enabled
   assign DATA_IN = DATA_OE ? DATA_OUT : host_d;

   // Read; strobe held until data shows, bounded
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      int n;
      d = 8'hxx;
      ADDR = a;
      CS_N = 1'b0;
      READ_STROBE_N = 1'b0;
      for (n = 0; n < 8 && DATA_OE !== 1'b1; n++) begin
         @(posedge CLK);
         #5;
      end
      if (DATA_OE === 1'b1) begin
         d = DATA_OUT;
      end else begin
         timeouts++;
      end
      CS_N = 1'b1;
      READ_STROBE_N = 1'b1;
      repeat (8) @(posedge CLK);
      #5;
   endtask

   // Write; data turns over once hold time is spent
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      ADDR = a;
      host_d = d;
      CS_N = 1'b0;
      WRITE_STROBE_N = 1'b0;
      repeat (5) @(posedge CLK);
      #5;
      CS_N = 1'b1;
      WRITE_STROBE_N = 1'b1;
      @(posedge CLK);
      #5;
      host_d = ~d;
      repeat (8) @(posedge CLK);
      #5;
   endtask
endmodule // iop_host_model

// [sim/iop_port_cmd_tb.sv]
// Self-checking bench for iop_port_cmd.
// Assumes the host model and the bound checker.
`timescale 1ns/100ps

module iop_port_cmd_tb;
   logic CLK, RST, CE, CS_N, READ_STROBE_N, WRITE_STROBE_N, DATA_OE, INT_N;
   logic COUNTER_START, COUNTER_STOP;
   logic [3:0] ADDR;
   logic [6:0] GENERAL_INPUTS;
   logic [7:0] DATA_IN, DATA_OUT, INTERRUPT_STATUS, OUTPUT_FUNCTION_SELECT, ALT_OUTPUTS;
   logic [7:0] GENERAL_OUTPUTS, OUTPUT_PORT_BITS, rd_d;
   logic [15:0] COUNT_VALUE;
   int error_cnt = 0;
   int checks = 0;
   int starts = 0;
   int stops = 0;
   logic [3:0] w_a [4] = '{4'hE, 4'hE, 4'hF, 4'hF};
   logic [7:0] w_d [4] = '{8'h05, 8'h30, 8'h01, 8'h00};
   logic [7:0] w_e [4] = '{8'h05, 8'h35, 8'h34, 8'h34};
   logic [7:0] i_m [6] = '{8'h40, 8'h40, 8'hC0, 8'hC0, 8'h00, 8'h80};
   logic [7:0] i_s [6] = '{8'h40, 8'h80, 8'h80, 8'h3F, 8'hFF, 8'h80};
   logic i_e [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

   iop_port_cmd i_dut (.CLK, .RST, .CE, .ADDR, .CS_N, .READ_STROBE_N, .WRITE_STROBE_N, .DATA_IN,
      .DATA_OUT, .DATA_OE, .GENERAL_INPUTS, .INTERRUPT_STATUS, .COUNT_VALUE, .OUTPUT_FUNCTION_SELECT,
      .ALT_OUTPUTS, .GENERAL_OUTPUTS, .OUTPUT_PORT_BITS, .INT_N, .COUNTER_START, .COUNTER_STOP);
   iop_host_model i_host (.CLK, .ADDR, .CS_N, .READ_STROBE_N, .WRITE_STROBE_N, .DATA_IN, .DATA_OUT,
      .DATA_OE);

   // ---------------------------------------------
   // Clock, pulse counters and helpers
   // ---------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   // Falling edge, away from the edge that launches the pulses
   always @(negedge CLK) begin
      if (COUNTER_START === 1'b1) starts++;
      if (COUNTER_STOP === 1'b1) stops++;
   end
   task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string name);
      i_host.rd(a, rd_d);
      cmp8(name, exp, rd_d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #5;
   endtask
   task automatic print_verdict;
      error_cnt += i_host.timeouts;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      {RST, CE} = 2'b11;
      {GENERAL_INPUTS, INTERRUPT_STATUS, OUTPUT_FUNCTION_SELECT, ALT_OUTPUTS} = '0;
      COUNT_VALUE = 16'hA53C;
      tick(2);
      RST = 1'b0;
      tick(3);
      cmp8("outputs", 8'hFF, GENERAL_OUTPUTS);
      cmp8("int", 8'h01, {7'h00, INT_N});
      rdc(4'h5, 8'h00, "mask");
      GENERAL_INPUTS = 7'h7F;
      rdc(4'hD, 8'h7F, "inputs");
      GENERAL_INPUTS = 7'h2A;
      rdc(4'hD, 8'h2A, "inputs");
      i_host.rd(4'hE, rd_d);
      cmp8("starts", 8'h01, 8'(starts));
      i_host.rd(4'hF, rd_d);
      cmp8("stops", 8'h01, 8'(stops));
      cmp8("starts", 8'h01, 8'(starts));
      rdc(4'h6, 8'hA5, "count high");
      rdc(4'h7, 8'h3C, "count low");
      rdc(4'h3, 8'h00, "unmapped");
      for (int i = 0; i < 4; i++) begin
         i_host.wr(w_a[i], w_d[i]);
         cmp8("port bits", w_e[i], OUTPUT_PORT_BITS);
         cmp8("outputs", ~w_e[i], GENERAL_OUTPUTS);
      end
      i_host.rd(4'hE, rd_d);
      i_host.rd(4'hF, rd_d);
      cmp8("starts", 8'h02, 8'(starts));
      cmp8("stops", 8'h02, 8'(stops));
      cmp8("port bits", 8'h34, OUTPUT_PORT_BITS);
      OUTPUT_FUNCTION_SELECT = 8'hF0;
      ALT_OUTPUTS = 8'hA5;
      tick(2);
      cmp8("outputs", 8'hAB, GENERAL_OUTPUTS);
      i_host.wr(4'hE, 8'hFF);
      cmp8("outputs", 8'hA0, GENERAL_OUTPUTS);
      OUTPUT_FUNCTION_SELECT = 8'h00;
      tick(2);
      cmp8("outputs", 8'h00, GENERAL_OUTPUTS);
      i_host.wr(4'hF, 8'hFF);
      cmp8("outputs", 8'hFF, GENERAL_OUTPUTS);
      for (int i = 0; i < 6; i++) begin
         i_host.wr(4'h5, i_m[i]);
         INTERRUPT_STATUS = i_s[i];
         tick(2);
         cmp8("int", {7'h00, i_e[i]}, {7'h00, INT_N});
      end
      i_host.rd(4'hE, rd_d);
      cmp8("starts", 8'h03, 8'(starts));
      rdc(4'h5, 8'h80, "mask");
      CE = 1'b0;
      INTERRUPT_STATUS = 8'h00;
      tick(3);
      cmp8("int frozen", 8'h00, {7'h00, INT_N});
      CE = 1'b1;
      tick(2);
      cmp8("int", 8'h01, {7'h00, INT_N});
      print_verdict();
   end
endmodule // iop_port_cmd_tb
